// >>> common/wake_regs.svh
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH
// register byte offsets
`define OFS_STS1 12'h000
`define OFS_STS3 12'h004
`define OFS_STS5 12'h008
`define OFS_STS6 12'h00c
`define OFS_EN1 12'h010
`define OFS_EN3 12'h014
`define OFS_EN5 12'h018
`define OFS_EN6 12'h01c
`define OFS_PIN_STS 12'h020
`define OFS_PIN_EN 12'h024
`define OFS_SYSMGMT_ENABLE_REG_TWO 12'h028
`define OFS_GPIO_CFG 12'h02c
`define OFS_PIN_CTRL 12'h030
`define OFS_SMI_SRC_EN 12'h034
// field positions
`define BIT_GROUP_INT 3
`define BIT_SMI_TO_WAKE 5
`define BIT_PIN_OD 7
`define BIT_PIN_POL 1
`define BIT_PIN_FUNC 0
`define BIT_LOWBAT 0
`define BIT_WDT 1
`define BIT_HWMON 2
// reset values
`define RST_PIN_CTRL 8'h80
`define RST_ZERO8 8'h00
`define RST_ZERO32 32'h0000_0000
`define RST_PIN_EN 8'h01
`define RST_ZERO12 12'h000
`define RST_ZERO4 4'h0
// sizes
`define NUM_GPIO 8
`define NUM_RI 6
`define NUM_SMI_SRC 8
`endif

// >>> common/wake_pkg.sv
package wake_pkg;
	// ahb data phase tracking
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b10
	} phase_t;
endpackage

// >>> src/wake_edge_sync.sv
`timescale 1ns/1ps
`include "wake_regs.svh"
// three-flop synchroniser and edge finder per gpio
module wake_edge_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [`NUM_GPIO-1:0] gpio_in,
	input wire logic [`NUM_GPIO-1:0] gpio_pol,
	input wire logic [`NUM_GPIO-1:0] gpio_both,
	output logic [`NUM_GPIO-1:0] gpio_edge,
	output logic [`NUM_GPIO-1:0] gpio_any_edge
);
	genvar i;
	generate
		for (i = 0; i < `NUM_GPIO; i = i + 1) begin : g_bit
			logic s1_ff, s2_ff, s3_ff; // s1 feeds s2 only
			logic nxt_s1, nxt_s2, nxt_s3;
			logic rise, fall;
			always_comb begin
				nxt_s1 = gpio_in[i];
				nxt_s2 = s1_ff;
				nxt_s3 = s2_ff;
			end
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
				end else begin
					s1_ff <= nxt_s1;
					s2_ff <= nxt_s2;
					s3_ff <= nxt_s3;
				end
			end
			// a change counts once stages two and three disagree, once only
			always_comb begin
				rise = s2_ff & ~s3_ff;
				fall = ~s2_ff & s3_ff;
				gpio_any_edge[i] = rise | fall;
				if (gpio_both[i]) begin
					gpio_edge[i] = rise | fall;
				end else begin
					gpio_edge[i] = gpio_pol[i] ? fall : rise;
				end
			end
		end
	endgenerate
endmodule

// >>> src/wake_event_aggregator.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "wake_regs.svh"
// How it works
// - status bits other than group bit three stay set until written one
// - each status register has matching enable register
// - status and enable set pin-status bit
// - pin-status and pin-enable drive wake output
// - gpio polarity picks edge, default rising
// - either-edge mode sets on both transitions
// - group interrupt status at bit three follows
// - group interrupt gated by enable bit five
// - group interrupt enable at bit three
// - pin polarity selects active high or low
// - bit seven selects open-drain or push-pull
// - reset: active-low open-drain, pin is gpio
// - output works in any sleep state
// - low battery latched only at power-on
// - hardware monitor has status and enable
// - edge status records regardless of enables
// - group interrupt is or of gated events
module wake_event_aggregator (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [`NUM_GPIO-1:0] gpio_in,
	input wire logic [`NUM_RI-1:0] ring_in_n,
	input wire logic kbd_wake,
	input wire logic mouse_wake,
	input wire logic wdt_timeout,
	input wire logic hwmon_event,
	input wire logic low_battery,
	input wire logic main_por_done,
	input wire logic [`NUM_SMI_SRC-1:0] smi_src_event,
	input wire logic shared_wake_pin_gpio_out,
	output logic shared_wake_pin_out,
	output logic shared_wake_pin_oe_n,
	output logic wake_event_out_n
);
	// registered bus state
	wake_pkg::phase_t ph_ff, nxt_ph;
	logic [11:0] addr_ff, nxt_addr;
	// status registers: sts1 gpio, sts3 misc, sts5 ring, sts6 keys
	logic [7:0] sts1_ff, sts3_ff, sts5_ff, sts6_ff;
	logic [7:0] nxt_sts1, nxt_sts3, nxt_sts5, nxt_sts6;
	logic [7:0] en1_ff, en3_ff, en5_ff, en6_ff;
	logic [7:0] nxt_en1, nxt_en3, nxt_en5, nxt_en6;
	logic [7:0] pin_en_ff, nxt_pin_en;
	logic [7:0] sysmgmt_enable_reg_two_ff, nxt_sysmgmt_enable_reg_two;
	logic [7:0] smi_src_en_ff, nxt_smi_src_en;
	logic [31:0] gpio_cfg_ff, nxt_gpio_cfg; // [7:0] pol, [15:8] both, [23:16] edge status
	logic [7:0] pin_ctrl_ff, nxt_pin_ctrl;
	logic [31:0] rdata_ff, nxt_rdata;
	logic por_seen_ff, nxt_por_seen;
	// synchronised asynchronous pins
	logic [`NUM_RI-1:0] ri1_ff, ri2_ff, ri3_ff;
	logic [3:0] ev1_ff, ev2_ff, ev3_ff; // kbd, mouse, wdt, hwmon
	logic [3:0] nxt_ev1, nxt_ev2, nxt_ev3;
	logic [`NUM_RI-1:0] nxt_ri1, nxt_ri2, nxt_ri3;
	logic [`NUM_GPIO-1:0] gpio_edge, gpio_any_edge;
	// combinational helpers
	logic [`NUM_RI-1:0] ri_fall;
	logic [3:0] ev_rise;
	logic group_smi, group_int;
	logic [7:0] pin_sts;
	logic wake_active;
	logic wr_en, rd_en;
	logic [7:0] wb;
	logic [7:0] sts1_keep; // gpio status bits that must survive this cycle

	wake_edge_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.gpio_in(gpio_in),
		.gpio_pol(gpio_cfg_ff[7:0]),
		.gpio_both(gpio_cfg_ff[15:8]),
		.gpio_edge(gpio_edge),
		.gpio_any_edge(gpio_any_edge)
	);

	// pin synchronisers for ring and internal-event inputs
	always_comb begin
		nxt_ri1 = ring_in_n;
		nxt_ri2 = ri1_ff;
		nxt_ri3 = ri2_ff;
		nxt_ev1 = {hwmon_event, wdt_timeout, mouse_wake, kbd_wake};
		nxt_ev2 = ev1_ff;
		nxt_ev3 = ev2_ff;
		ri_fall = ri3_ff & ~ri2_ff; // ring assert is active low
		ev_rise = ev2_ff & ~ev3_ff;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ri1_ff <= {`NUM_RI{1'b1}};
			ri2_ff <= {`NUM_RI{1'b1}};
			ri3_ff <= {`NUM_RI{1'b1}};
			ev1_ff <= `RST_ZERO4;
			ev2_ff <= `RST_ZERO4;
			ev3_ff <= `RST_ZERO4;
		end else begin
			ri1_ff <= nxt_ri1;
			ri2_ff <= nxt_ri2;
			ri3_ff <= nxt_ri3;
			ev1_ff <= nxt_ev1;
			ev2_ff <= nxt_ev2;
			ev3_ff <= nxt_ev3;
		end
	end

	// group interrupt: each event gated directly by its enable
	always_comb begin
		group_smi = |(smi_src_event & smi_src_en_ff);
		group_int = group_smi & sysmgmt_enable_reg_two_ff[`BIT_SMI_TO_WAKE];
	end

	// ahb-lite slave: zero wait states, always okay
	always_comb begin
		wr_en = (ph_ff == wake_pkg::PH_WRITE);
		rd_en = hsel & hready & htrans[1] & ~hwrite;
		wb = hwdata[7:0];
		nxt_ph = wake_pkg::PH_IDLE;
		nxt_addr = addr_ff;
		if (hsel && hready && htrans[1]) begin
			nxt_ph = hwrite ? wake_pkg::PH_WRITE : wake_pkg::PH_READ;
			nxt_addr = haddr;
		end
		hreadyout = 1'b1;
		hresp = 1'b0;
	end

	// bits set now and not written one this cycle; only the sticky check reads it
	always_comb begin
		sts1_keep = sts1_ff;
		if (wr_en && addr_ff == `OFS_STS1) begin
			sts1_keep = sts1_ff & ~wb;
		end
	end

	// status, enable and config next values
	always_comb begin
		nxt_sts1 = sts1_ff;
		nxt_sts3 = sts3_ff;
		nxt_sts5 = sts5_ff;
		nxt_sts6 = sts6_ff;
		nxt_en1 = en1_ff;
		nxt_en3 = en3_ff;
		nxt_en5 = en5_ff;
		nxt_en6 = en6_ff;
		nxt_pin_en = pin_en_ff;
		nxt_sysmgmt_enable_reg_two = sysmgmt_enable_reg_two_ff;
		nxt_smi_src_en = smi_src_en_ff;
		nxt_gpio_cfg = gpio_cfg_ff;
		nxt_pin_ctrl = pin_ctrl_ff;
		nxt_por_seen = por_seen_ff;
		// write-one-to-clear first, so events below override it
		if (wr_en) begin
			case (addr_ff)
				`OFS_STS1: nxt_sts1 = sts1_ff & ~wb;
				`OFS_STS3: nxt_sts3 = sts3_ff & ~wb;
				`OFS_STS5: nxt_sts5 = sts5_ff & ~wb;
				`OFS_STS6: nxt_sts6 = sts6_ff & ~wb;
				`OFS_EN1: nxt_en1 = wb;
				`OFS_EN3: nxt_en3 = wb;
				`OFS_EN5: nxt_en5 = wb;
				`OFS_EN6: nxt_en6 = wb;
				`OFS_PIN_EN: nxt_pin_en = wb;
				`OFS_SYSMGMT_ENABLE_REG_TWO: nxt_sysmgmt_enable_reg_two = wb;
				`OFS_SMI_SRC_EN: nxt_smi_src_en = wb;
				`OFS_GPIO_CFG: begin
					nxt_gpio_cfg[15:0] = hwdata[15:0];
					nxt_gpio_cfg[23:16] = gpio_cfg_ff[23:16] & ~hwdata[23:16];
				end
				`OFS_PIN_CTRL: nxt_pin_ctrl = wb;
				default: begin
				end
			endcase
		end
		// events set; set beats a same-cycle clear
		nxt_sts1 = nxt_sts1 | gpio_edge;
		nxt_gpio_cfg[23:16] = nxt_gpio_cfg[23:16] | gpio_any_edge;
		nxt_sts5 = nxt_sts5 | {2'b00, ri_fall};
		nxt_sts6 = nxt_sts6 | {6'b00_0000, ev_rise[1:0]};
		nxt_sts3[`BIT_WDT] = nxt_sts3[`BIT_WDT] | ev_rise[2];
		nxt_sts3[`BIT_HWMON] = nxt_sts3[`BIT_HWMON] | ev_rise[3];
		// low battery sampled once, first cycle after power-on release
		if (!por_seen_ff && main_por_done) begin
			nxt_por_seen = 1'b1;
			nxt_sts3[`BIT_LOWBAT] = nxt_sts3[`BIT_LOWBAT] | low_battery;
		end
		// group bit is a live level, not sticky
		nxt_sts3[`BIT_GROUP_INT] = group_int;
	end

	// read mux, low byte used except gpio config
	always_comb begin
		nxt_rdata = rdata_ff;
		if (rd_en) begin
			case (haddr)
				`OFS_STS1: nxt_rdata = {24'h00_0000, sts1_ff};
				`OFS_STS3: nxt_rdata = {24'h00_0000, sts3_ff};
				`OFS_STS5: nxt_rdata = {24'h00_0000, sts5_ff};
				`OFS_STS6: nxt_rdata = {24'h00_0000, sts6_ff};
				`OFS_EN1: nxt_rdata = {24'h00_0000, en1_ff};
				`OFS_EN3: nxt_rdata = {24'h00_0000, en3_ff};
				`OFS_EN5: nxt_rdata = {24'h00_0000, en5_ff};
				`OFS_EN6: nxt_rdata = {24'h00_0000, en6_ff};
				`OFS_PIN_STS: nxt_rdata = {24'h00_0000, pin_sts};
				`OFS_PIN_EN: nxt_rdata = {24'h00_0000, pin_en_ff};
				`OFS_SYSMGMT_ENABLE_REG_TWO: nxt_rdata = {24'h00_0000, sysmgmt_enable_reg_two_ff};
				`OFS_SMI_SRC_EN: nxt_rdata = {24'h00_0000, smi_src_en_ff};
				`OFS_GPIO_CFG: nxt_rdata = {8'h00, gpio_cfg_ff[23:0]};
				`OFS_PIN_CTRL: nxt_rdata = {24'h00_0000, pin_ctrl_ff};
				default: nxt_rdata = `RST_ZERO32; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_ff <= wake_pkg::PH_IDLE;
			addr_ff <= `RST_ZERO12;
			sts1_ff <= `RST_ZERO8;
			sts3_ff <= `RST_ZERO8;
			sts5_ff <= `RST_ZERO8;
			sts6_ff <= `RST_ZERO8;
			en1_ff <= `RST_ZERO8;
			en3_ff <= `RST_ZERO8;
			en5_ff <= `RST_ZERO8;
			en6_ff <= `RST_ZERO8;
			pin_en_ff <= `RST_PIN_EN;
			sysmgmt_enable_reg_two_ff <= `RST_ZERO8;
			smi_src_en_ff <= `RST_ZERO8;
			gpio_cfg_ff <= `RST_ZERO32; // non-inverted by default
			pin_ctrl_ff <= `RST_PIN_CTRL;
			rdata_ff <= `RST_ZERO32;
			por_seen_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			addr_ff <= nxt_addr;
			sts1_ff <= nxt_sts1;
			sts3_ff <= nxt_sts3;
			sts5_ff <= nxt_sts5;
			sts6_ff <= nxt_sts6;
			en1_ff <= nxt_en1;
			en3_ff <= nxt_en3;
			en5_ff <= nxt_en5;
			en6_ff <= nxt_en6;
			pin_en_ff <= nxt_pin_en;
			sysmgmt_enable_reg_two_ff <= nxt_sysmgmt_enable_reg_two;
			smi_src_en_ff <= nxt_smi_src_en;
			gpio_cfg_ff <= nxt_gpio_cfg;
			pin_ctrl_ff <= nxt_pin_ctrl;
			rdata_ff <= nxt_rdata;
			por_seen_ff <= nxt_por_seen;
		end
	end

	assign hrdata = rdata_ff;

	// pin status per status register; group bit enabled by en3 bit 3
	always_comb begin
		pin_sts = 8'h00;
		pin_sts[0] = |(sts1_ff & en1_ff);
		pin_sts[1] = |(sts3_ff & en3_ff); // group enable is en3[3]
		pin_sts[2] = |(sts5_ff & en5_ff);
		pin_sts[3] = |(sts6_ff & en6_ff);
		wake_active = |(pin_sts[3:0] & {4{pin_en_ff[0]}});
	end

	// output pin; no sleep-state gating so it works down to the deepest state
	always_comb begin
		wake_event_out_n = ~wake_active;
		if (pin_ctrl_ff[`BIT_PIN_FUNC]) begin
			// level is active-high when polarity bit set
			shared_wake_pin_out = pin_ctrl_ff[`BIT_PIN_POL] ? wake_active : ~wake_active;
			// open drain drives only the low level
			if (pin_ctrl_ff[`BIT_PIN_OD]) begin
				shared_wake_pin_oe_n = shared_wake_pin_out;
			end else begin
				shared_wake_pin_oe_n = 1'b0;
			end
		end else begin
			shared_wake_pin_out = shared_wake_pin_gpio_out; // gpio default
			shared_wake_pin_oe_n = 1'b0;
		end
	end

	AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
		(|sts1_keep) |=> ((sts1_ff & $past(sts1_keep)) == $past(sts1_keep)))
		else $error("status bit dropped without clear");
	AST_PIN_STS: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(sts1_ff & en1_ff)) |-> pin_sts[0]) else $error("pin status not set");
	AST_WAKE_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_sts[0] && pin_en_ff[0]) |-> !wake_event_out_n) else $error("wake not driven");
	AST_GROUP: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 sts3_ff[`BIT_GROUP_INT] == $past(group_int)) else $error("group bit mismatch");
	AST_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
		!sysmgmt_enable_reg_two_ff[`BIT_SMI_TO_WAKE] |-> !group_int) else $error("group leaked");
	AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
		(|gpio_edge) |=> ((sts1_ff & $past(gpio_edge)) == $past(gpio_edge)))
		else $error("edge lost");
	AST_HWMON: assert property (@(posedge hclk) disable iff (!hresetn)
		ev_rise[3] |=> sts3_ff[`BIT_HWMON]) else $error("monitor event lost");
	AST_OD: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_ctrl_ff[`BIT_PIN_FUNC] && pin_ctrl_ff[`BIT_PIN_OD] && shared_wake_pin_out)
		|-> shared_wake_pin_oe_n) else $error("open drain drove high");
	AST_LOWBAT: assert property (@(posedge hclk) disable iff (!hresetn)
		(por_seen_ff && !sts3_ff[`BIT_LOWBAT]) |=> !sts3_ff[`BIT_LOWBAT])
		else $error("low battery set after power-on");
endmodule

// >>> bench/chipset_wake_input.sv
`timescale 1ns/1ps
// far side: chipset wake input, board pull-up on the line
module chipset_wake_input (
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic pin_level
);
	// released line rises to the pull-up, never keeps the last value
	assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule

// >>> bench/wake_event_aggregator_tb.sv
`timescale 1ns/1ps
`include "wake_regs.svh"
module wake_event_aggregator_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, rd_dp;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, exp_v;
	logic [7:0] gpio_in, smi_src_event;
	logic [5:0] ring_in_n;
	logic kbd_wake, mouse_wake, wdt_timeout, hwmon_event, low_battery, main_por_done;
	logic gpio_out, pin_out, pin_oe_n, wake_event_out_n, pin_level, hresp;
	logic [31:0] exp_q[$]; // expected read data, oldest first
	int n_mismatch = 0;
	int cmp_count = 0;
	int b, k, r;
	wake_event_aggregator i_wake_event_aggregator (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .gpio_in(gpio_in), .ring_in_n(ring_in_n), .kbd_wake(kbd_wake),
		.mouse_wake(mouse_wake), .wdt_timeout(wdt_timeout), .hwmon_event(hwmon_event),
		.low_battery(low_battery), .main_por_done(main_por_done),
		.smi_src_event(smi_src_event), .shared_wake_pin_gpio_out(gpio_out),
		.shared_wake_pin_out(pin_out), .shared_wake_pin_oe_n(pin_oe_n),
		.wake_event_out_n(wake_event_out_n));
	chipset_wake_input i_chipset_wake_input (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_level(pin_level));
	// 200 mhz clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// pin states as one triple {wake_n, oe_n, level}
	task automatic chk_pins(input logic [2:0] e);
		cmp_count++;
		if ({wake_event_out_n, pin_oe_n, pin_level} !== e) begin
			n_mismatch++;
			$display("Error pins expected %b seen %b", e, {wake_event_out_n, pin_oe_n, pin_level});
		end
	endtask
	// bounded wait for hready high at a rising edge
	task automatic wt_rdy();
		int i;
		@(posedge hclk);
		for (i = 0; i < 50 && hreadyout !== 1'b1; i++)
			@(posedge hclk);
		if (i == 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	// one single-word transfer: address phase, then data phase
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		wt_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wt_rdy();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(a, 1'b0, 32'h0000_0000);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// pins compared mid-cycle, once register updates have landed: {wake_n, oe_n, level}
	task automatic pins(input logic [2:0] e);
		@(negedge hclk);
		chk_pins(e);
		@(posedge hclk);
	endtask
	task automatic pctl(input logic [31:0] c, input logic [2:0] e);
		wr(`OFS_PIN_CTRL, c);
		pins(e);
	endtask
	// read data is taken at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_dp === 1'b1) begin
			exp_v = exp_q.pop_front();
			chk("hrdata", exp_v, hrdata);
			chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
		end
		rd_dp = hsel & htrans[1] & ~hwrite & hreadyout;
	end
	// hang guard
	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{hresetn, hsel, hwrite, rd_dp, kbd_wake, mouse_wake} = 6'b0;
		{wdt_timeout, hwmon_event, low_battery, main_por_done} = 4'b0;
		{haddr, htrans, hsize, hwdata} = 49'h0;
		{gpio_in, smi_src_event} = 16'h0000;
		ring_in_n = 6'h3f;
		void'($urandom(88878));
		gpio_out = 1'($urandom % 2);
		b = $urandom % 8;
		k = $urandom % 8;
		r = $urandom % 6;
		cyc(20);
		hresetn <= 1'b1;
		cyc(1);
		rd(`OFS_PIN_CTRL, 32'h0000_0080);
		rd(`OFS_PIN_EN, 32'h0000_0001);
		rd(`OFS_STS1, 32'h0000_0000);
		pins({1'b1, 1'b0, gpio_out});
		$display("test reset done");
		gpio_in[b] <= 1'b1;
		cyc(6);
		rd(`OFS_STS1, 32'h1 << b);
		gpio_in[b] <= 1'b0;
		cyc(6);
		rd(`OFS_STS1, 32'h1 << b);
		rd(`OFS_GPIO_CFG, 32'h1 << (b + 16));
		wr(`OFS_STS1, 32'h1 << b);
		rd(`OFS_STS1, 32'h0000_0000);
		// falling polarity; the switch itself may look like an edge, so clear after
		wr(`OFS_GPIO_CFG, (32'h1 << (b + 16)) | (32'h1 << b));
		cyc(6);
		wr(`OFS_STS1, 32'h0000_00ff);
		gpio_in[b] <= 1'b1;
		cyc(6);
		rd(`OFS_STS1, 32'h0000_0000);
		gpio_in[b] <= 1'b0;
		cyc(6);
		rd(`OFS_STS1, 32'h1 << b);
		wr(`OFS_GPIO_CFG, 32'h1 << (b + 8));
		cyc(6);
		wr(`OFS_STS1, 32'h0000_00ff);
		gpio_in[b] <= 1'b1;
		cyc(6);
		rd(`OFS_STS1, 32'h1 << b);
		wr(`OFS_STS1, 32'h1 << b);
		gpio_in[b] <= 1'b0;
		cyc(6);
		rd(`OFS_STS1, 32'h1 << b);
		$display("test gpio done");
		wr(`OFS_EN1, 32'h1 << b);
		rd(`OFS_PIN_STS, 32'h0000_0001);
		pins({1'b0, 1'b0, gpio_out});
		wr(`OFS_PIN_EN, 32'h0000_0000);
		pins({1'b1, 1'b0, gpio_out});
		wr(`OFS_PIN_EN, 32'h0000_0001);
		pctl(32'h0000_0081, 3'b000);
		pctl(32'h0000_0003, 3'b001);
		pctl(32'h0000_0001, 3'b000);
		pctl(32'h0000_0083, 3'b011);
		wr(`OFS_STS1, 32'h0000_00ff);
		pctl(32'h0000_0081, 3'b111);
		pctl(32'h0000_0003, 3'b100);
		$display("test pin done");
		wr(`OFS_SYSMGMT_ENABLE_REG_TWO, 32'h0000_0020);
		wr(`OFS_SMI_SRC_EN, 32'h1 << k);
		smi_src_event <= 8'(32'h1 << ((k + 1) % 8));
		cyc(2);
		rd(`OFS_STS3, 32'h0000_0000);
		smi_src_event <= 8'(32'h1 << k);
		cyc(2);
		rd(`OFS_STS3, 32'h0000_0008);
		wr(`OFS_SYSMGMT_ENABLE_REG_TWO, 32'h0000_0000);
		// the live group bit lags its gate by one register stage
		cyc(1);
		rd(`OFS_STS3, 32'h0000_0000);
		wr(`OFS_SYSMGMT_ENABLE_REG_TWO, 32'h0000_0020);
		wr(`OFS_EN3, 32'h0000_0008);
		rd(`OFS_PIN_STS, 32'h0000_0002);
		pins({1'b0, 1'b0, 1'b1});
		smi_src_event <= 8'h00;
		cyc(2);
		rd(`OFS_STS3, 32'h0000_0000);
		pins({1'b1, 1'b0, 1'b0});
		$display("test group done");
		{wdt_timeout, hwmon_event, kbd_wake, mouse_wake} <= 4'hf;
		ring_in_n[r] <= 1'b0;
		cyc(6);
		rd(`OFS_STS3, 32'h0000_0006);
		rd(`OFS_STS6, 32'h0000_0003);
		rd(`OFS_STS5, 32'h1 << r);
		wr(`OFS_STS3, 32'h0000_00ff);
		wr(`OFS_STS6, 32'h0000_00ff);
		cyc(6);
		rd(`OFS_STS3, 32'h0000_0000);
		rd(`OFS_STS6, 32'h0000_0000);
		low_battery <= 1'b1;
		main_por_done <= 1'b1;
		cyc(6);
		rd(`OFS_STS3, 32'h0000_0001);
		wr(`OFS_STS3, 32'h0000_0001);
		cyc(6);
		rd(`OFS_STS3, 32'h0000_0000);
		$display("test sources done");
		cyc(2);
		give_verdict();
	end
endmodule
